// ===== verilog/vid_pkg.sv
// vid_pkg: constants, register map and types of the vectored interrupt dispatch block
// assumes a 100 MHz core clock, AXI4-Lite register access and a byte-wide program memory port
`default_nettype none
package vid_pkg;
  localparam int unsigned NUM_RANKS = 16;
  localparam int unsigned PC_W = 15;
  localparam logic [7:0] SLOT_BASE = 8'he0;
  localparam logic [7:0] SLOT_TRAP = 8'hfe;
  localparam logic [7:0] SLOT_LO_STEP = 8'h01;
  localparam int unsigned RANK_TRAP = 15;
  // maskable ranks: external, timers, serial, usart, port edge; reserved ranks 14 and 8 never fire
  localparam logic [15:0] SRC_VALID = 16'h3efe;
  // register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  // status / mask fields
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_DEFAULT = 1;
  localparam int unsigned EV_TRAP = 2;
  // result register fields
  localparam int unsigned RES_TRAP_BIT = 31;
  localparam int unsigned RES_SLOT_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_HI, ST_LO, ST_LOAD} vid_state_t;
endpackage
`default_nettype wire

// ===== verilog/vid_arb_if.sv
// vid_arb_if: active rank lines and arbitration result between the sequencer and the encoder
// assumes both ends share one clock domain; the encoder is purely combinational
`timescale 1ns/100ps
`default_nettype none
interface vid_arb_if;
  logic [15:0] active;
  logic [3:0] win_idx;
  logic [7:0] slot;
  modport arb (input active, output win_idx, output slot);
  modport core (output active, input win_idx, input slot);
endinterface
`default_nettype wire

// ===== verilog/vid_arbiter.sv
// vid_arbiter: fixed-priority encoder over sixteen rank lines forming the vector slot byte
// assumes rank 0 (default) is always driven high by the caller, so a winner always exists
`timescale 1ns/100ps
`default_nettype none
module vid_arbiter
  import vid_pkg::*;
(
  vid_arb_if.arb arb
);
  function automatic logic [3:0] top_index(input logic [15:0] lines);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < NUM_RANKS; i++) begin
      if (lines[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  assign arb.win_idx = top_index(arb.active);
  assign arb.slot = SLOT_BASE + {3'h0, arb.win_idx, 1'b0};
endmodule
`default_nettype wire

// ===== verilog/vid_dispatch.sv
// vid_dispatch: vectored dispatch sequencer with trap pending flag and AXI4-Lite registers
// assumes pending and control pulses come from core logic on aclk; program memory answers
// a held read with a one-cycle ack, and a new address under a held read starts a new read
`timescale 1ns/100ps
`default_nettype none
module vid_dispatch
  import vid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] src_pending,
  input wire logic trap_opcode,
  input wire logic clear_trap_pending_instruction,
  input wire logic vector_dispatch_instruction,
  input wire logic [PC_W-1:0] pc_advanced,
  output logic mem_rd,
  output logic [PC_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_data,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic dispatch_busy,
  output logic trap_pending_flag,
  output logic irq
);
  vid_arb_if arb_bus ();
  vid_arbiter u_arb (.arb(arb_bus.arb));

  vid_state_t state;
  vid_state_t next_state;
  logic [15:0] src_enable;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] irq_mask;
  logic [7:0] last_slot;
  logic [PC_W-1:0] last_vector;
  logic [6:0] vec_hi;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // decode shared by the write and read paths; 4'h0 means unmapped
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    return {a == REG_RESULT, a == REG_MASK, a == REG_STATUS, a == REG_ENABLE};
  endfunction

  // arbitration inputs: trap on top, maskable lines gated, default always present
  wire logic [15:0] gated_src = src_pending & src_enable & SRC_VALID;
  wire logic [14:0] masked_mid = trap_pending_flag ? 15'h0000 : gated_src[14:0];
  assign arb_bus.active = {trap_pending_flag, masked_mid[14:1], 1'b1};

  // dispatch sequencing
  wire logic start = vector_dispatch_instruction && (state == ST_IDLE);
  wire logic hi_done = (state == ST_HI) && mem_ack;
  wire logic lo_done = (state == ST_LO) && mem_ack;
  // upper byte from the counter already past the opcode gives next-block placement at offset ff
  wire logic [PC_W-1:0] slot_addr = {pc_advanced[PC_W-1:8], arb_bus.slot};
  // slot byte is even and at most fe, so the low-byte step never carries into the block
  wire logic [PC_W-1:0] lo_addr = {mem_addr[PC_W-1:8], mem_addr[7:0] | SLOT_LO_STEP};
  wire logic [PC_W-1:0] vector = {vec_hi, mem_data};

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start) next_state = ST_HI;
      ST_HI: if (mem_ack) next_state = ST_LO;
      ST_LO: if (mem_ack) next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      dispatch_busy <= 1'b0;
      mem_rd <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      dispatch_busy <= (next_state != ST_IDLE);
      mem_rd <= (next_state == ST_HI) || (next_state == ST_LO);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr <= '0;
      last_slot <= SLOT_BASE;
      vec_hi <= '0;
    end else if (ce) begin
      if (start) begin
        mem_addr <= slot_addr;
        last_slot <= arb_bus.slot;
      end else if (hi_done) begin
        mem_addr <= lo_addr;
        vec_hi <= mem_data[6:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_load <= 1'b0;
      pc_value <= '0;
      last_vector <= '0;
    end else if (ce) begin
      pc_load <= lo_done;
      if (lo_done) begin
        pc_value <= vector;
        last_vector <= vector;
      end
    end
  end

  // set wins: a trap fetched in the clearing cycle must not be lost
  wire logic next_trap = trap_opcode || (trap_pending_flag && !clear_trap_pending_instruction);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_pending_flag <= 1'b0;
    end else if (ce) begin
      trap_pending_flag <= next_trap;
    end
  end

  // register bus: address and data taken in either order, response once both are held
  wire logic aw_hs = s_axi_awvalid && s_axi_awready;
  wire logic w_hs = s_axi_wvalid && s_axi_wready;
  wire logic wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic b_hs = s_axi_bvalid && s_axi_bready;
  wire logic ar_hs = s_axi_arvalid && s_axi_arready;
  wire logic r_hs = s_axi_rvalid && s_axi_rready;
  wire logic [3:0] wr_sel = reg_sel(aw_addr);
  wire logic [3:0] rd_sel = reg_sel(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) s_axi_awready <= 1'b0;
      else if (b_hs) s_axi_awready <= 1'b1;
      if (w_hs) s_axi_wready <= 1'b0;
      else if (b_hs) s_axi_wready <= 1'b1;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == 4'h0) ? RESP_DECERR : RESP_OKAY;
      end else if (b_hs) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (aw_hs) aw_addr <= s_axi_awaddr;
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // register writes; status clears by writing ones, hardware events win over the clear
  wire logic wr_en = wr_go && wr_sel[0];
  wire logic [15:0] en_strb = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire logic [15:0] next_enable = wr_en ? ((src_enable & ~en_strb) | (w_data[15:0] & en_strb)) & SRC_VALID
                                        : src_enable;
  wire logic [EV_W-1:0] ev = {trap_opcode, start && (arb_bus.win_idx == 4'h0), lo_done};
  wire logic [EV_W-1:0] st_clr = (wr_go && wr_sel[1] && w_strb[0]) ? w_data[EV_W-1:0] : '0;
  wire logic [EV_W-1:0] next_status = (status & ~st_clr) | ev;
  wire logic mask_wr = wr_go && wr_sel[2] && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_enable <= ENABLE_RST;
      status <= STATUS_RST;
      irq_mask <= MASK_RST;
      irq <= 1'b0;
    end else if (ce) begin
      src_enable <= next_enable;
      status <= next_status;
      if (mask_wr) irq_mask <= w_data[EV_W-1:0];
      irq <= |(status & irq_mask);
    end
  end

  wire logic [31:0] result_word = {trap_pending_flag, 7'h00, last_slot, 1'b0, last_vector};
  wire logic [31:0] rd_mux = ({32{rd_sel[0]}} & {16'h0000, src_enable}) |
                             ({32{rd_sel[1]}} & {29'h0, status}) |
                             ({32{rd_sel[2]}} & {29'h0, irq_mask}) |
                             ({32{rd_sel[3]}} & result_word);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (rd_sel == 4'h0) ? RESP_DECERR : RESP_OKAY;
      end else if (r_hs) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // checks; all state freezes with ce low, so they sleep then as well
  wire logic higher_clear = ((arb_bus.active >> arb_bus.win_idx) >> 1) == 16'h0000;
  wire logic win_active = arb_bus.active[arb_bus.win_idx];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  a_trap_clear: assert property (clear_trap_pending_instruction && !trap_opcode |=> !trap_pending_flag)
    else $error("trap flag survived its clear");
  a_trap_set_wins: assert property (trap_opcode |=> trap_pending_flag)
    else $error("trap fetch did not set the flag");
  a_trap_slot: assert property (start && trap_pending_flag |=> last_slot == SLOT_TRAP && mem_addr[7:0] == SLOT_TRAP)
    else $error("trap pending but trap slot not chosen");
  a_default_slot: assert property (start && arb_bus.active[15:1] == 15'h0000 |=> last_slot == SLOT_BASE)
    else $error("idle dispatch missed default slot");
  a_slot_range: assert property (last_slot[0] == 1'b0 && last_slot >= SLOT_BASE)
    else $error("slot byte odd or below base");
  a_rank_win: assert property (start |-> higher_clear && win_active)
    else $error("arbiter skipped a higher active rank");
  a_upper_keep: assert property (start |=> mem_addr[PC_W-1:8] == $past(pc_advanced[PC_W-1:8]) && mem_rd)
    else $error("slot address upper byte altered");
  a_enable_gate: assert property (start && !trap_pending_flag && gated_src == 16'h0000 |=> last_slot == SLOT_BASE)
    else $error("disabled source won arbitration");
  a_lo_step: assert property (hi_done |=> mem_addr[7:0] == $past(mem_addr[7:0]) + SLOT_LO_STEP && state == ST_LO)
    else $error("low vector byte address wrong");
  a_pc_load: assert property (lo_done |=> pc_load && pc_value == {vec_hi, $past(mem_data)} ##1 !pc_load && !dispatch_busy)
    else $error("vector not loaded into counter");
  a_irq_level: assert property (##1 irq == $past(|(status & irq_mask)))
    else $error("interrupt output mismatches status and mask");

  // sequencing: a fetch address must sit still until memory answers it
  a_busy_state: assert property (dispatch_busy == (state != ST_IDLE))
    else $error("busy flag disagrees with sequencer state");
  a_rd_state: assert property (mem_rd == (state == ST_HI || state == ST_LO))
    else $error("read request outside a fetch state");
  a_start_read: assert property (start |=> state == ST_HI && mem_rd && dispatch_busy)
    else $error("dispatch start did not begin the high byte fetch");
  a_busy_ignore: assert property (vector_dispatch_instruction && dispatch_busy |=> $stable(last_slot))
    else $error("dispatch pulse while busy changed the slot");
  a_slot_match: assert property (start |=> last_slot == mem_addr[7:0])
    else $error("slot byte not placed in address low byte");
  a_hi_addr: assert property (state == ST_HI |-> mem_addr[0] == 1'b0 && mem_addr[7:5] == 3'h7)
    else $error("high byte fetch outside the table top");
  a_lo_addr: assert property (state == ST_LO |-> mem_addr[0] == 1'b1)
    else $error("low byte fetch from an even address");
  a_mem_hold: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("read request dropped or moved before its answer");
  a_hi_capture: assert property (hi_done |=> vec_hi == $past(mem_data[6:0]))
    else $error("high vector byte not captured");
  a_load_pulse: assert property (pc_load |=> !pc_load)
    else $error("counter load longer than one cycle");
  a_pc_hold: assert property (!lo_done |=> $stable(pc_value))
    else $error("counter value changed without a load");
  a_vec_record: assert property (lo_done |=> last_vector == pc_value)
    else $error("result vector differs from loaded value");
  a_status_done: assert property (lo_done |=> status[EV_DONE])
    else $error("done event not recorded");

  // arbitration and trap flag
  a_trap_hold: assert property (trap_pending_flag && !clear_trap_pending_instruction |=> trap_pending_flag)
    else $error("trap flag dropped without a clear");
  a_trap_no_self: assert property (!trap_pending_flag && !trap_opcode |=> !trap_pending_flag)
    else $error("trap flag rose without a trap fetch");
  a_trap_event: assert property (trap_opcode |=> status[EV_TRAP])
    else $error("trap event not recorded");
  a_trap_inhibit: assert property (trap_pending_flag |-> arb_bus.win_idx == 4'hf)
    else $error("trap flag set but another rank wins");
  a_win_gated: assert property (!trap_pending_flag && arb_bus.win_idx != 4'h0 |-> gated_src[arb_bus.win_idx])
    else $error("winning rank not enabled and pending");
  a_enable_legal: assert property ((src_enable & ~SRC_VALID) == 16'h0000)
    else $error("enable bit held for an unused rank");
  a_default_event: assert property (start && arb_bus.win_idx == 4'h0 |=> status[EV_DEFAULT])
    else $error("default dispatch not recorded");

  // register bus; the master may stall either response for any number of cycles
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before it was taken");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while a response waits");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while data waits");
  a_wr_decerr: assert property (wr_go && wr_sel == 4'h0 |=> s_axi_bvalid && s_axi_bresp == RESP_DECERR)
    else $error("unmapped write not refused");
  a_rd_decerr: assert property (ar_hs && rd_sel == 4'h0 |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_status_set: assert property (|ev |=> (status & $past(ev)) == $past(ev))
    else $error("status event lost to a clear");
  a_mask_hold: assert property (!mask_wr |=> $stable(irq_mask))
    else $error("mask changed without a write");
  a_irq_low: assert property ((status & irq_mask) == 3'h0 |=> !irq)
    else $error("interrupt raised with nothing unmasked");

  // ce low must freeze every flop, so this check keeps only the reset disable
  a_ce_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    !ce |=> $stable(state) && $stable(trap_pending_flag) && $stable(status) && $stable(irq))
    else $error("state moved while clock enable was low");

  c_trap_dispatch: cover property (start && trap_pending_flag ##[1:20] pc_load);
  c_default_dispatch: cover property (start && arb_bus.win_idx == 4'h0 ##[1:20] pc_load);
  c_maskable_dispatch: cover property (start && !trap_pending_flag && gated_src != 16'h0000 ##[1:20] pc_load);
  c_irq_raised: cover property (!irq ##1 irq);
  c_slow_fetch: cover property (mem_rd && !mem_ack ##1 mem_rd && !mem_ack ##1 mem_rd && !mem_ack);
endmodule
`default_nettype wire

// ===== dv/vid_mem_model.sv
// vid_mem_model: byte-wide program memory answering the dispatch sequencer's held reads
// assumes one clock; the bench fills mem and may slow answers through wait_cycles
`timescale 1ns/100ps
`default_nettype none
module vid_mem_model (
  input wire logic aclk,
  input wire logic mem_rd,
  input wire logic [14:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_data
);
  logic [7:0] mem [0:32767];
  int wait_cycles = 0;
  int cnt = 0;
  initial begin
    mem_ack = 1'b0;
    mem_data = 8'h5a;
  end
  // outside an ack the data bus toggles so stale bytes are never mistaken for answers
  always @(posedge aclk) begin
    if (mem_rd && !mem_ack && cnt >= wait_cycles) begin
      mem_ack <= 1'b1;
      mem_data <= mem[mem_addr];
      cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      if (mem_rd && !mem_ack) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_vid_dispatch.sv
// tb_vid_dispatch: self-checking bench for the vectored dispatch block
// assumes vid_pkg constants; memory partner is vid_mem_model, registers over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module tb_vid_dispatch
  import vid_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] src_pending = 16'h0;
  logic trap_op = 1'b0, trap_clr = 1'b0, disp = 1'b0;
  logic [14:0] pc_adv = 15'h0, mem_addr, pc_value;
  logic mem_rd, mem_ack, pc_load, busy, trap_flag, irq;
  logic [7:0] mem_data;
  logic [31:0] d;
  logic [1:0] r;
  int num_errors = 0, checks_done = 0, cyc = 0, loads = 0, l0;

  vid_dispatch DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_pending(src_pending), .trap_opcode(trap_op), .clear_trap_pending_instruction(trap_clr),
    .vector_dispatch_instruction(disp), .pc_advanced(pc_adv), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_data(mem_data), .pc_load(pc_load), .pc_value(pc_value),
    .dispatch_busy(busy), .trap_pending_flag(trap_flag), .irq(irq));
  vid_mem_model mem_i (.aclk(aclk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_data(mem_data));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pc_load === 1'b1) begin
      loads <= loads + 1;
    end
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [7:0] tbl_byte(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction

  function automatic logic [14:0] exp_vec(input logic [14:0] a);
    logic [7:0] h;
    h = tbl_byte(a);
    return {h[6:0], tbl_byte(a + 15'h1)};
  endfunction

  // one dispatch: slot address, fetched vector, and exactly one load pulse
  task automatic dispatch(input logic [14:0] pc, input logic [7:0] slot);
    logic [14:0] base;
    base = {pc[14:8], slot};
    l0 = loads;
    @(posedge aclk);
    disp <= 1'b1;
    pc_adv <= pc;
    @(posedge aclk);
    disp <= 1'b0;
    // waits end only through the bench timeout, which counts as a mismatch
    while (mem_rd !== 1'b1) begin
      @(posedge aclk);
    end
    chk("slot_addr", {17'h0, mem_addr}, {17'h0, base});
    while (pc_load !== 1'b1) begin
      @(posedge aclk);
    end
    chk("pc_value", {17'h0, pc_value}, {17'h0, exp_vec(base)});
    while (busy !== 1'b0) begin
      @(posedge aclk);
    end
    @(posedge aclk);
    chk("load_pulses", 32'(loads - l0), 32'd1);
  endtask

  task automatic trap_ctl(input logic set, input logic clr);
    @(posedge aclk);
    trap_op <= set;
    trap_clr <= clr;
    @(posedge aclk);
    trap_op <= 1'b0;
    trap_clr <= 1'b0;
    @(posedge aclk);
  endtask

  initial begin
    for (int a = 'h100; a < 'h300; a++) mem_i.mem[a] = tbl_byte(15'(a));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_ENABLE, d, r);
    chk("enable_rst", d, 32'h0);
    rd(REG_RESULT, d, r);
    chk("result_rst", d, {8'h00, SLOT_BASE, 16'h0000});
    rd(8'h10, d, r);
    chk("unmapped_rresp", {30'h0, r}, {30'h0, RESP_DECERR});
    wr(8'h10, 32'hffffffff, r);
    chk("unmapped_bresp", {30'h0, r}, {30'h0, RESP_DECERR});
    wr(REG_ENABLE, 32'hffffffff, r);
    rd(REG_ENABLE, d, r);
    chk("enable_bits", d, {16'h0, SRC_VALID});
    // every maskable rank pending together with all below it: the top one must win
    for (int k = 1; k < 15; k++) begin
      if (SRC_VALID[k]) begin
        src_pending <= 16'((32'h1 << (k + 1)) - 1);
        dispatch(15'h0123, SLOT_BASE + 8'(2 * k));
      end
    end
    wr(REG_ENABLE, {16'h0, SRC_VALID & ~16'h1000}, r);
    src_pending <= 16'h1008;
    dispatch(15'h0123, 8'he6);
    wr(REG_ENABLE, {16'h0, SRC_VALID}, r);
    wr(REG_STATUS, 32'h7, r);
    src_pending <= 16'h4101;
    dispatch(15'h0155, SLOT_BASE);
    rd(REG_STATUS, d, r);
    chk("status_default", d, 32'h3);
    wr(REG_MASK, 32'h2, r);
    repeat (3) @(posedge aclk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(REG_STATUS, 32'h2, r);
    repeat (3) @(posedge aclk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    src_pending <= 16'h1000;
    dispatch(15'h0200, 8'hf8);
    trap_ctl(1'b1, 1'b0);
    chk("trap_set", {31'h0, trap_flag}, 32'h1);
    src_pending <= 16'h3efe;
    dispatch(15'h0123, SLOT_TRAP);
    rd(REG_RESULT, d, r);
    chk("result_trap", d, {1'b1, 7'h0, SLOT_TRAP, 1'b0, exp_vec(15'h01fe)});
    trap_ctl(1'b1, 1'b1);
    chk("trap_both", {31'h0, trap_flag}, 32'h1);
    trap_ctl(1'b0, 1'b1);
    chk("trap_clear", {31'h0, trap_flag}, 32'h0);
    // a trap fetch while the clock enable is low must leave the flag alone
    @(posedge aclk);
    ce <= 1'b0;
    trap_op <= 1'b1;
    @(posedge aclk);
    ce <= 1'b1;
    trap_op <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("ce_freeze", {31'h0, trap_flag}, 32'h0);
    // slow memory; a second dispatch pulse during the sequence must be ignored
    mem_i.wait_cycles = 4;
    l0 = loads;
    @(posedge aclk);
    disp <= 1'b1;
    pc_adv <= 15'h0123;
    src_pending <= 16'h1000;
    @(posedge aclk);
    disp <= 1'b0;
    @(posedge aclk);
    disp <= 1'b1;
    pc_adv <= 15'h0200;
    src_pending <= 16'h0002;
    @(posedge aclk);
    disp <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("busy_ignored", 32'(loads - l0), 32'd1);
    chk("slow_vector", {17'h0, pc_value}, {17'h0, exp_vec(15'h01f8)});
    report_and_stop();
  end
endmodule
`default_nettype wire
